// ---- vac_pkg.sv ----
package vac_pkg;

  // Host I/O port addresses
  localparam logic [15:0] VAC_PORT_WRITE = 16'h03c0;
  localparam logic [15:0] VAC_PORT_READ = 16'h03c1;
  localparam logic [15:0] VAC_PORT_STAT_MONO = 16'h03ba;
  localparam logic [15:0] VAC_PORT_STAT_COLOUR = 16'h03da;

  // Attribute register indices
  localparam logic [4:0] VAC_IDX_PAL_LAST = 5'h0f;
  localparam logic [4:0] VAC_IDX_MODE = 5'h10;
  localparam logic [4:0] VAC_IDX_BORDER = 5'h11;
  localparam logic [4:0] VAC_IDX_PLANE = 5'h12;
  localparam logic [4:0] VAC_IDX_PAN = 5'h13;
  localparam logic [4:0] VAC_IDX_CSEL = 5'h14;

  // Index register fields
  localparam int VAC_IDX_PAS_BIT = 5;

  // Mode control fields
  localparam int VAC_MODE_GFX = 0;
  localparam int VAC_MODE_MONO = 1;
  localparam int VAC_MODE_LINEGFX = 2;
  localparam int VAC_MODE_BLINK = 3;
  localparam int VAC_MODE_PANCOMPAT = 5;
  localparam int VAC_MODE_PELWIDTH = 6;
  localparam int VAC_MODE_CSEL54 = 7;

  // Status register 1 fields
  localparam int VAC_STAT_DISP_BIT = 0;
  localparam int VAC_STAT_VSYNC_BIT = 3;

  // Panning limits
  localparam logic [3:0] VAC_PAN_MAX_9DOT = 4'h8;
  localparam logic [3:0] VAC_PAN_MAX_8DOT = 4'h7;

  // Values after reset
  localparam logic [5:0] VAC_RST_INDEX = 6'h00;
  localparam logic [7:0] VAC_RST_MODE = 8'h00;
  localparam logic [7:0] VAC_RST_BORDER = 8'h00;
  localparam logic [5:0] VAC_RST_PLANE = 6'h0f;
  localparam logic [3:0] VAC_RST_PAN = 4'h0;
  localparam logic [3:0] VAC_RST_CSEL = 4'h0;

  // Cycles from a read strobe to its answer
  localparam int VAC_READ_LATENCY = 2;

  typedef enum logic {
    VAC_PH_INDEX = 1'b0,
    VAC_PH_DATA = 1'b1
  } vac_phase_t;

endpackage

// ---- vac_palette_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
module vac_palette_ram #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 6,
  parameter int AW = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_pix_addr,
  output logic [WIDTH-1:0] o_pix_data,
  input wire logic [AW-1:0] i_cpu_addr,
  output logic [WIDTH-1:0] o_cpu_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array has no reset; software loads every entry before use
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pix_data <= '0;
      o_cpu_data <= '0;
    end else begin
      o_pix_data <= mem[i_pix_addr];
      o_cpu_data <= mem[i_cpu_addr];
    end
  end

endmodule // vac_palette_ram
`default_nettype wire

// ---- vac_attr_ctrl.sv ----
// Behaviour
// - Status register 1 read resets access flip-flop
// - Write port alternates index then data
// - Separate read port returns selected register
// - Index picks palette, mode, border, plane, pan, select
// - Index bit 5 clear blanks video output
// - Pixel selects six-bit palette colour
// - Mode bit 7 substitutes colour select bits
// - Mode bit 6 halves the pixel clock
// - Line compare zeroes panning until vertical sync
// - Mode bit 3 picks blink or intensity
// - Mode bit 2 copies eighth dot ninth
// - Mode bit 1 selects monochrome attributes
// - Mode bit 0 selects graphics mode
// - Border register drives colour in overscan
// - Plane enables mask pixel bits
// - Plane bits 5:4 route colours to status
// - Misc output bit 0 moves status port
// - Panning shift depends on character width
// - Colour select drives top bits except 256
`timescale 1ns/1ps
`default_nettype none
module vac_attr_ctrl
  import vac_pkg::*;
#(
  parameter int PAL_DEPTH = 16,
  parameter int PAL_WIDTH = 6
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // Host I/O
  input wire logic [15:0] I_IO_ADDR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [7:0] I_IO_WDATA,
  output logic [7:0] O_IO_RDATA,
  output logic O_IO_RVALID,
  input wire logic I_MISC_COLOUR_ADDR,
  // Timing from the CRT side
  input wire logic I_VSYNC,
  input wire logic I_DISP_INACTIVE,
  input wire logic I_LINE_COMPARE,
  input wire logic I_NINE_DOT,
  input wire logic I_BLINK_PHASE,
  // Pixel stream in
  input wire logic I_PIX_VALID,
  output logic O_PIX_READY,
  input wire logic [3:0] I_PIX_DATA,
  input wire logic [3:0] I_PIX_BG,
  input wire logic I_PIX_DOT,
  input wire logic I_PIX_NINTH,
  input wire logic I_PIX_LINE_CHAR,
  input wire logic I_PIX_PREV_DOT,
  input wire logic I_PIX_BORDER,
  // Colour stream out to the DAC
  output logic O_COLOUR_VALID,
  input wire logic I_COLOUR_READY,
  output logic [7:0] O_COLOUR,
  output logic O_PCLK_EN,
  output logic [3:0] O_PAN_SHIFT,
  output logic O_SKEW_DISABLE
);

  vac_phase_t phase;
  logic [5:0] index;
  logic [7:0] mode;
  logic [7:0] border;
  logic [5:0] plane;
  logic [3:0] pan;
  logic [3:0] csel;
  logic [7:0] last_colour;
  logic lc_lock;
  logic rd_pend;
  logic [15:0] rd_addr;
  logic s1_valid;
  logic s1_border;
  logic half;
  logic [3:0] hi_nibble;
  logic [7:0] skid_data;
  logic skid_valid;
  logic [PAL_WIDTH-1:0] pal_pix;
  logic [PAL_WIDTH-1:0] pal_cpu;

  logic stat_hit;
  logic wr_port;
  logic wr_data;
  logic pal_we;
  logic accept;
  logic out_take;
  logic s1_emit;
  logic [7:0] s1_colour;
  logic [3:0] pix_index;
  logic next_out_valid;
  logic next_skid_valid;
  logic next_s1_valid;

  function automatic logic [15:0] stat_port(input logic colour_addr);
    stat_port = colour_addr ? VAC_PORT_STAT_COLOUR : VAC_PORT_STAT_MONO;
  endfunction

  // Ninth column, blink and monochrome handling for text modes
  function automatic logic [3:0] text_index(
    input logic [7:0] m,
    input logic [3:0] fg,
    input logic [3:0] bg,
    input logic dot,
    input logic ninth,
    input logic line_char,
    input logic prev_dot,
    input logic blink_phase
  );
    logic d;
    logic [3:0] b;
    d = dot;
    b = bg;
    if (ninth) begin
      d = m[VAC_MODE_LINEGFX] & line_char & prev_dot;
    end
    if (m[VAC_MODE_BLINK]) begin
      b[3] = 1'b0;
      if (bg[3] && !blink_phase) begin
        d = 1'b0;
      end
    end
    if (m[VAC_MODE_MONO]) begin
      text_index = d ? {fg[3], {3{|fg[2:0]}}}
                     : {b[3], {3{|b[2:0]}}};
    end else begin
      text_index = d ? fg : b;
    end
  endfunction

  // Effective left shift; 256-colour mode moves in pixel pairs
  function automatic logic [3:0] pan_shift(
    input logic [3:0] v,
    input logic wide,
    input logic nine
  );
    if (wide) begin
      pan_shift = (v <= VAC_PAN_MAX_8DOT) ? {2'b00, v[2:1]} : 4'h0;
    end else if (nine) begin
      pan_shift = (v < VAC_PAN_MAX_9DOT) ? 4'(v + 4'h1) : 4'h0;
    end else begin
      pan_shift = (v <= VAC_PAN_MAX_8DOT) ? v : 4'h0;
    end
  endfunction

  // Host port decode
  assign stat_hit = I_IO_RD && (I_IO_ADDR == stat_port(I_MISC_COLOUR_ADDR));
  assign wr_port = I_IO_WR && (I_IO_ADDR == VAC_PORT_WRITE);
  assign wr_data = wr_port && (phase == VAC_PH_DATA);
  assign pal_we = wr_data && (index[4:0] <= VAC_IDX_PAL_LAST);

  // Access flip-flop; a status read outranks a same-cycle write
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      phase <= VAC_PH_INDEX;
    end else if (stat_hit) begin
      phase <= VAC_PH_INDEX;
    end else if (wr_port) begin
      phase <= (phase == VAC_PH_INDEX) ? VAC_PH_DATA : VAC_PH_INDEX;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      index <= VAC_RST_INDEX;
    end else if (wr_port && phase == VAC_PH_INDEX) begin
      index <= I_IO_WDATA[5:0];
    end
  end

  // Data registers; mode and border keep all eight bits, plane, pan and select drop their upper bits
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode <= VAC_RST_MODE;
      border <= VAC_RST_BORDER;
      plane <= VAC_RST_PLANE;
      pan <= VAC_RST_PAN;
      csel <= VAC_RST_CSEL;
    end else if (wr_data) begin
      unique case (index[4:0])
        VAC_IDX_MODE: mode <= I_IO_WDATA;
        VAC_IDX_BORDER: border <= I_IO_WDATA;
        VAC_IDX_PLANE: plane <= I_IO_WDATA[5:0];
        VAC_IDX_PAN: pan <= I_IO_WDATA[3:0];
        VAC_IDX_CSEL: csel <= I_IO_WDATA[3:0];
        default: ;
      endcase
    end
  end

  // Reads answer two cycles after the strobe so the palette read port can settle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_pend <= 1'b0;
      rd_addr <= 16'h0000;
    end else begin
      rd_pend <= I_IO_RD;
      rd_addr <= I_IO_ADDR;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_IO_RDATA <= 8'h00;
      O_IO_RVALID <= 1'b0;
    end else begin
      O_IO_RVALID <= rd_pend;
      if (rd_pend) begin
        if (rd_addr == VAC_PORT_WRITE) begin
          O_IO_RDATA <= {2'b00, index};
        end else if (rd_addr == VAC_PORT_READ) begin
          if (index[4:0] <= VAC_IDX_PAL_LAST) begin
            O_IO_RDATA <= 8'({2'b00, pal_cpu});
          end else begin
            unique case (index[4:0])
              VAC_IDX_MODE: O_IO_RDATA <= mode;
              VAC_IDX_BORDER: O_IO_RDATA <= border;
              VAC_IDX_PLANE: O_IO_RDATA <= {2'b00, plane};
              VAC_IDX_PAN: O_IO_RDATA <= {4'h0, pan};
              VAC_IDX_CSEL: O_IO_RDATA <= {4'h0, csel};
              default: O_IO_RDATA <= 8'h00;
            endcase
          end
        end else if (rd_addr == stat_port(I_MISC_COLOUR_ADDR)) begin
          O_IO_RDATA <= 8'h00;
          O_IO_RDATA[VAC_STAT_DISP_BIT] <= I_DISP_INACTIVE;
          O_IO_RDATA[VAC_STAT_VSYNC_BIT] <= I_VSYNC;
          unique case (plane[5:4])
            2'b00: O_IO_RDATA[5:4] <= {last_colour[2], last_colour[0]};
            2'b01: O_IO_RDATA[5:4] <= {last_colour[5], last_colour[4]};
            2'b10: O_IO_RDATA[5:4] <= {last_colour[3], last_colour[1]};
            2'b11: O_IO_RDATA[5:4] <= {last_colour[7], last_colour[6]};
          endcase
        end else begin
          O_IO_RDATA <= 8'h00;
        end
      end
    end
  end

  // Line compare lock; a compare in the vsync cycle still sets it
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lc_lock <= 1'b0;
    end else if (I_LINE_COMPARE && mode[VAC_MODE_PANCOMPAT]) begin
      lc_lock <= 1'b1;
    end else if (I_VSYNC) begin
      lc_lock <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PAN_SHIFT <= 4'h0;
      O_SKEW_DISABLE <= 1'b0;
    end else begin
      O_PAN_SHIFT <= lc_lock ? 4'h0
                     : pan_shift(pan, mode[VAC_MODE_PELWIDTH], I_NINE_DOT);
      O_SKEW_DISABLE <= lc_lock;
    end
  end

  // Pixel clock enable: every cycle, or every other in 256-colour mode
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PCLK_EN <= 1'b1;
    end else begin
      O_PCLK_EN <= mode[VAC_MODE_PELWIDTH] ? ~O_PCLK_EN : 1'b1;
    end
  end

  // Palette address from the incoming pixel
  always_comb begin
    if (mode[VAC_MODE_GFX]) begin
      pix_index = I_PIX_DATA;
    end else begin
      pix_index = text_index(mode, I_PIX_DATA, I_PIX_BG, I_PIX_DOT,
                             I_PIX_NINTH, I_PIX_LINE_CHAR, I_PIX_PREV_DOT,
                             I_BLINK_PHASE);
    end
    pix_index = pix_index & plane[3:0];
  end

  vac_palette_ram #(
    .DEPTH(PAL_DEPTH),
    .WIDTH(PAL_WIDTH),
    .AW(4)
  ) u_pal (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_we(pal_we),
    .i_waddr(index[3:0]),
    .i_wdata(I_IO_WDATA[PAL_WIDTH-1:0]),
    .i_pix_addr(pix_index),
    .o_pix_data(pal_pix),
    .i_cpu_addr(index[3:0]),
    .o_cpu_data(pal_cpu)
  );

  assign accept = I_PIX_VALID && O_PIX_READY;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s1_valid <= 1'b0;
      s1_border <= 1'b0;
    end else begin
      s1_valid <= accept;
      s1_border <= I_PIX_BORDER;
    end
  end

  // Colour formation after the palette
  always_comb begin
    s1_emit = s1_valid;
    s1_colour = {csel[3:2], pal_pix[5:4], pal_pix[3:0]};
    if (mode[VAC_MODE_CSEL54]) begin
      s1_colour[5:4] = csel[1:0];
    end
    if (mode[VAC_MODE_PELWIDTH]) begin
      s1_colour = {hi_nibble, pal_pix[3:0]};
      s1_emit = s1_valid && half;
    end
    if (s1_border) begin
      s1_colour = border;
      s1_emit = s1_valid;
    end
    if (!index[VAC_IDX_PAS_BIT]) begin
      s1_colour = 8'h00;
    end
  end

  // Two nibbles make one 256-colour pixel, first is the high half
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      half <= 1'b0;
      hi_nibble <= 4'h0;
    end else if (!mode[VAC_MODE_PELWIDTH] || (s1_valid && s1_border)) begin
      half <= 1'b0;
    end else if (s1_valid) begin
      half <= ~half;
      if (!half) begin
        hi_nibble <= pal_pix[3:0];
      end
    end
  end

  // Two-entry buffer: output register plus skid register
  assign out_take = O_COLOUR_VALID && I_COLOUR_READY;

  always_comb begin
    next_out_valid = O_COLOUR_VALID;
    next_skid_valid = skid_valid;
    if (out_take) begin
      next_out_valid = skid_valid | s1_emit;
      next_skid_valid = skid_valid & s1_emit;
    end else if (s1_emit) begin
      next_out_valid = 1'b1;
      next_skid_valid = O_COLOUR_VALID;
    end
    next_s1_valid = accept;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_COLOUR_VALID <= 1'b0;
      O_COLOUR <= 8'h00;
      skid_valid <= 1'b0;
      skid_data <= 8'h00;
    end else begin
      O_COLOUR_VALID <= next_out_valid;
      skid_valid <= next_skid_valid;
      if (out_take || !O_COLOUR_VALID) begin
        O_COLOUR <= skid_valid ? skid_data : s1_colour;
        skid_data <= s1_colour;
      end else if (s1_emit) begin
        skid_data <= s1_colour;
      end
    end
  end

  // Ready counts the word in flight, so no word is lost on a stall;
  // the price is half rate once the buffer holds a word
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PIX_READY <= 1'b0;
    end else begin
      O_PIX_READY <= (2'(next_out_valid) + 2'(next_skid_valid)
                      + 2'(next_s1_valid)) < 2'd2;
    end
  end

  // Colour seen by the status multiplexer
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      last_colour <= 8'h00;
    end else if (s1_emit) begin
      last_colour <= s1_colour;
    end
  end

endmodule // vac_attr_ctrl
`default_nettype wire

// ---- vac_attr_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module vac_attr_ctrl_chk (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_IO_RD,
  input wire logic [7:0] O_IO_RDATA,
  input wire logic O_IO_RVALID,
  input wire logic I_VSYNC,
  input wire logic I_LINE_COMPARE,
  input wire logic O_COLOUR_VALID,
  input wire logic I_COLOUR_READY,
  input wire logic [7:0] O_COLOUR,
  input wire logic O_PCLK_EN,
  input wire logic [3:0] O_PAN_SHIFT,
  input wire logic O_SKEW_DISABLE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  read_answer_a: assert property (
    I_IO_RD |-> ##2 O_IO_RVALID) else $error("Read answer missing");
  answer_cause_a: assert property (
    O_IO_RVALID |-> $past(I_IO_RD, 2)) else $error("Answer without read");
  rdata_hold_a: assert property (
    !O_IO_RVALID |-> $stable(O_IO_RDATA)) else $error("Read data moved");
  colour_hold_a: assert property (
    O_COLOUR_VALID && !I_COLOUR_READY |=> O_COLOUR_VALID && $stable(O_COLOUR))
    else $error("Colour dropped under stall");
  pclk_low_a: assert property (
    !O_PCLK_EN |=> O_PCLK_EN) else $error("Pixel clock low twice");
  pan_limit_a: assert property (
    O_PAN_SHIFT <= 4'h8) else $error("Pan shift too large");
  lock_zero_a: assert property (
    $rose(O_SKEW_DISABLE) |-> ##[0:1] O_PAN_SHIFT == 4'h0)
    else $error("Pan not zero in lock");
  lock_cause_a: assert property (
    $rose(O_SKEW_DISABLE) |-> $past(I_LINE_COMPARE)
    || $past(I_LINE_COMPARE, 2)) else $error("Lock without compare");
  lock_clear_a: assert property (
    I_VSYNC && !I_LINE_COMPARE ##1 I_VSYNC && !I_LINE_COMPARE
    |=> !O_SKEW_DISABLE) else $error("Vsync left lock set");
endmodule // vac_attr_ctrl_chk
bind vac_attr_ctrl vac_attr_ctrl_chk chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
  .I_IO_RD(I_IO_RD), .O_IO_RDATA(O_IO_RDATA), .O_IO_RVALID(O_IO_RVALID),
  .I_VSYNC(I_VSYNC), .I_LINE_COMPARE(I_LINE_COMPARE),
  .O_COLOUR_VALID(O_COLOUR_VALID), .I_COLOUR_READY(I_COLOUR_READY),
  .O_COLOUR(O_COLOUR), .O_PCLK_EN(O_PCLK_EN), .O_PAN_SHIFT(O_PAN_SHIFT),
  .O_SKEW_DISABLE(O_SKEW_DISABLE));
`default_nettype wire

// ---- vac_dac_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vac_dac_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_hold,
  input wire logic i_valid,
  input wire logic [7:0] i_colour,
  output logic o_ready,
  output logic [7:0] o_last,
  output logic [7:0] o_cnt
);
  // Stalls every other cycle, and every cycle while i_hold is set, so the buffer's hold path always runs
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_ready <= 1'b0;
    else o_ready <= !i_hold && !o_ready;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_last <= 8'h00;
      o_cnt <= 8'h00;
    end else if (i_valid && o_ready) begin
      o_last <= i_colour;
      o_cnt <= o_cnt + 8'h01;
    end
  end
endmodule // vac_dac_model
`default_nettype wire

// ---- tb_vac_attr_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_vac_attr_ctrl;
  import vac_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] a = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic [3:0] pd = 4'h0, bg = 4'h0;
  logic wr = 1'b0, rd = 1'b0, misc = 1'b0, vs = 1'b0, di = 1'b0;
  logic lc = 1'b0, nd = 1'b0, pv = 1'b0, pb = 1'b0, dt = 1'b0, hold = 1'b0;
  logic bp = 1'b1, nn = 1'b0, lch = 1'b0, pdot = 1'b0;
  logic [7:0] rdata, col, last, cnt;
  logic [3:0] pan;
  logic rvalid, prdy, cval, crdy, pclk, skew, p1;
  int error_cnt = 0;
  int checks = 0;
  int i, k;
  localparam logic [7:0] RV [5] = '{VAC_RST_MODE, VAC_RST_BORDER,
    {2'b00, VAC_RST_PLANE}, {4'h0, VAC_RST_PAN}, {4'h0, VAC_RST_CSEL}};
  // Status bits 5:4 for border 0xa5 under each mux selection
  localparam logic [1:0] MX [4] = '{2'b11, 2'b10, 2'b00, 2'b10};
  always #2.5 clk = ~clk;
  vac_attr_ctrl uut (.I_CLK(clk), .I_RSTN(rstn), .I_IO_ADDR(a),
    .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wd), .O_IO_RDATA(rdata),
    .O_IO_RVALID(rvalid), .I_MISC_COLOUR_ADDR(misc), .I_VSYNC(vs),
    .I_DISP_INACTIVE(di), .I_LINE_COMPARE(lc), .I_NINE_DOT(nd),
    .I_BLINK_PHASE(bp), .I_PIX_VALID(pv), .O_PIX_READY(prdy),
    .I_PIX_DATA(pd), .I_PIX_BG(bg), .I_PIX_DOT(dt), .I_PIX_NINTH(nn),
    .I_PIX_LINE_CHAR(lch), .I_PIX_PREV_DOT(pdot), .I_PIX_BORDER(pb),
    .O_COLOUR_VALID(cval), .I_COLOUR_READY(crdy), .O_COLOUR(col),
    .O_PCLK_EN(pclk), .O_PAN_SHIFT(pan), .O_SKEW_DISABLE(skew));
  vac_dac_model dac (.i_clk(clk), .i_rstn(rstn), .i_hold(hold),
    .i_valid(cval), .i_colour(col), .o_ready(crdy), .o_last(last),
    .o_cnt(cnt));
  function automatic logic [5:0] pal(input logic [3:0] n);
    return {n[1:0], ~n};
  endfunction
  task automatic wrap_up();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    wrap_up();
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_io(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_io(input logic [15:0] ad, input logic [7:0] e);
    int n;
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
    if (rvalid !== 1'b1) tmo();
    cmp(rdata, e);
    // Realign so later pin changes fall on a rising edge
    @(posedge clk);
  endtask
  task automatic setr(input logic [7:0] ix, input logic [7:0] d);
    wr_io(VAC_PORT_WRITE, ix);
    wr_io(VAC_PORT_WRITE, d);
  endtask
  task automatic px(input logic [3:0] d, input logic b);
    int n;
    @(posedge clk);
    pv <= 1'b1;
    pd <= d;
    pb <= b;
    @(negedge clk);
    for (n = 0; n < 40 && prdy !== 1'b1; n++) @(negedge clk);
    if (prdy !== 1'b1) tmo();
    @(posedge clk);
    pv <= 1'b0;
  endtask
  task automatic col_chk(input logic [3:0] d, input logic b,
      input logic [7:0] e);
    logic [7:0] n;
    int m;
    n = cnt;
    px(d, b);
    for (m = 0; m < 40 && cnt === n; m++) @(negedge clk);
    if (cnt === n) tmo();
    cmp(last, e);
    @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_io(VAC_PORT_WRITE, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr_io(VAC_PORT_WRITE, 8'(VAC_IDX_MODE) + 8'(i));
      rd_io(VAC_PORT_READ, RV[i]);
      rd_io(VAC_PORT_STAT_MONO, 8'h00);
    end
    $display("reset values done");
    setr(8'h11, 8'ha5);
    rd_io(VAC_PORT_READ, 8'ha5);
    rd_io(VAC_PORT_READ, 8'ha5);
    wr_io(VAC_PORT_WRITE, 8'h13);
    rd_io(VAC_PORT_WRITE, 8'h13);
    rd_io(VAC_PORT_STAT_MONO, 8'h00);
    wr_io(VAC_PORT_WRITE, 8'h14);
    rd_io(VAC_PORT_WRITE, 8'h14);
    rd_io(VAC_PORT_STAT_MONO, 8'h00);
    $display("flip-flop done");
    di <= 1'b1;
    vs <= 1'b1;
    rd_io(VAC_PORT_STAT_MONO, 8'h09);
    rd_io(VAC_PORT_STAT_COLOUR, 8'h00);
    misc <= 1'b1;
    rd_io(VAC_PORT_STAT_COLOUR, 8'h09);
    rd_io(VAC_PORT_STAT_MONO, 8'h00);
    misc <= 1'b0;
    di <= 1'b0;
    vs <= 1'b0;
    $display("status port done");
    for (i = 0; i < 16; i++) begin
      setr(8'(i), {2'b00, pal(4'(i))});
      rd_io(VAC_PORT_READ, {2'b00, pal(4'(i))});
    end
    setr(8'h15, 8'hff);
    rd_io(VAC_PORT_READ, 8'h00);
    setr(8'h10, 8'h01);
    setr(8'h14, 8'h0c);
    wr_io(VAC_PORT_WRITE, 8'h20);
    for (i = 0; i < 16; i++)
      col_chk(4'(i), 1'b0, {2'b11, pal(4'(i))});
    rd_io(VAC_PORT_STAT_MONO, 8'h00);
    setr(8'h30, 8'h81);
    setr(8'h34, 8'h0e);
    col_chk(4'h9, 1'b0, 8'he6);
    setr(8'h32, 8'h05);
    col_chk(4'hf, 1'b0, 8'hea);
    col_chk(4'h3, 1'b1, 8'ha5);
    for (i = 0; i < 4; i++) begin
      setr(8'h32, {2'b00, 2'(i), 4'hf});
      col_chk(4'h0, 1'b1, 8'ha5);
      rd_io(VAC_PORT_STAT_MONO, {2'b00, MX[i], 4'h0});
    end
    setr(8'h10, 8'h01);
    col_chk(4'h3, 1'b0, 8'h00);
    setr(8'h30, 8'h00);
    bg <= 4'h5;
    dt <= 1'b1;
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h3)});
    dt <= 1'b0;
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h5)});
    setr(8'h30, 8'h04);
    nn <= 1'b1;
    lch <= 1'b1;
    pdot <= 1'b1;
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h3)});
    setr(8'h30, 8'h00);
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h5)});
    nn <= 1'b0;
    setr(8'h30, 8'h08);
    bg <= 4'hd;
    bp <= 1'b0;
    dt <= 1'b1;
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h5)});
    bp <= 1'b1;
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h3)});
    setr(8'h30, 8'h00);
    dt <= 1'b0;
    col_chk(4'h3, 1'b0, {2'b11, pal(4'hd)});
    dt <= 1'b1;
    setr(8'h30, 8'h02);
    col_chk(4'h3, 1'b0, {2'b11, pal(4'h7)});
    $display("colour path done");
    hold <= 1'b1;
    k = 0;
    @(posedge clk);
    pv <= 1'b1;
    repeat (10) begin
      @(negedge clk);
      if (prdy === 1'b1) k++;
    end
    @(posedge clk);
    pv <= 1'b0;
    cmp(8'(k), 8'h02);
    i = int'(cnt);
    hold <= 1'b0;
    for (k = 0; k < 40 && cnt !== 8'(i + 2); k++) @(negedge clk);
    cmp(cnt, 8'(i + 2));
    $display("buffer done");
    setr(8'h33, 8'h03);
    nd <= 1'b1;
    repeat (3) @(negedge clk);
    cmp({4'h0, pan}, 8'h04);
    @(posedge clk);
    nd <= 1'b0;
    repeat (3) @(negedge clk);
    cmp({4'h0, pan}, 8'h03);
    setr(8'h30, 8'h20);
    @(posedge clk);
    lc <= 1'b1;
    @(posedge clk);
    lc <= 1'b0;
    repeat (3) @(negedge clk);
    cmp({7'h0, skew}, 8'h01);
    cmp({4'h0, pan}, 8'h00);
    @(posedge clk);
    vs <= 1'b1;
    repeat (3) @(posedge clk);
    vs <= 1'b0;
    repeat (3) @(negedge clk);
    cmp({4'h0, pan}, 8'h03);
    setr(8'h30, 8'h40);
    repeat (3) @(negedge clk);
    p1 = pclk;
    @(negedge clk);
    cmp({7'h0, p1 ^ pclk}, 8'h01);
    // Wide pixels pair up: first nibble lands in the upper half
    setr(8'h30, 8'h41);
    px(4'h1, 1'b0);
    col_chk(4'h2, 1'b0, 8'hed);
    setr(8'h33, 8'h06);
    repeat (3) @(negedge clk);
    cmp({4'h0, pan}, 8'h03);
    $display("pan and clock done");
    wrap_up();
  end
endmodule // tb_vac_attr_ctrl
`default_nettype wire
